/* design/ssf_pkg.sv */
package ssf_pkg;

    localparam int NM = 7;
    localparam int NS = 6;
    localparam int PW = 3;
    localparam int DW = 128;
    localparam int CW = 32;
    localparam int AW = 32;
    localparam int OW = $clog2(NM);

    // clk_sys is taken to be the divided fabric clock already
    localparam int CPU_CLK_DIV = 3;
    localparam int FABRIC_CLK_MHZ = 200;

    // master indices
    localparam int M_TC0 = 0;
    localparam int M_TC1 = 1;
    localparam int M_TC2 = 2;
    localparam int M_TC3 = 3;
    localparam int M_ETH = 4;
    localparam int M_HOST = 5;
    localparam int M_PCI = 6;

    // slave indices on the data fabric
    localparam logic [2:0] S_SER = 3'h0;
    localparam logic [2:0] S_CFG = 3'h1;
    localparam logic [2:0] S_PCI = 3'h2;
    localparam logic [2:0] S_DDR = 3'h3;
    localparam logic [2:0] S_EXT = 3'h4;
    localparam logic [2:0] S_MEGA = 3'h5;

    // reach per master, one bit per slave index
    localparam logic [NM-1:0][NS-1:0] REACH = {
        6'h3A, 6'h3A, 6'h38, 6'h3C, 6'h3C, 6'h3F, 6'h38
    };

    // lane width and beat count of each slave attachment
    localparam int SL_LANE [NS] = '{32, 32, 128, 64, 64, 128};
    localparam int SL_BEATS [NS] = '{1, 1, 1, 2, 2, 1};

    // configuration fabric
    localparam int CFG_NC = 8;
    localparam int CFG_EP_LSB = 16;
    localparam logic [CFG_NC-1:0] CFG_CPU_ONLY = 8'h07;
    localparam logic [PW-1:0] CPU_PRI = 3'h0;
    localparam logic [PW-1:0] PRI_LOWEST = 3'h7;

    typedef enum logic [1:0] {
        SSF_IDLE = 2'b00,
        SSF_XFER = 2'b01,
        SSF_RESP = 2'b11
    } ssf_state_t;

endpackage : ssf_pkg

/* design/ssf_arb.sv */
`timescale 1ns/10ps
module ssf_arb #(
    parameter int N = 7
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [N-1:0] req,
    input wire logic [N-1:0][2:0] pri,
    output logic [N-1:0] gnt,
    output logic [$clog2(N)-1:0] win
);

    localparam int IW = $clog2(N);

    logic [IW-1:0] ptr_reg;
    logic [2:0] best;
    logic found;
    int j;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        best = ssf_pkg::PRI_LOWEST;
        gnt = '0;
        win = '0;
        found = 1'b0;
        j = 0;
        for (int i = 0; i < N; i++) begin
            if (req[i] && pri[i] < best) begin
                best = pri[i];
            end
        end
        for (int k = 0; k < N; k++) begin
            j = int'(ptr_reg) + k;
            if (j >= N) begin
                j = j - N;
            end
            if (!found && req[j] && pri[j] == best) begin
                found = 1'b1;
                gnt[j] = 1'b1;
                win = IW'(j);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pointer moves past the winner so equal codes take turns
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_reg <= '0;
        end else if (found) begin
            if (int'(win) == N - 1) begin
                ptr_reg <= '0;
            end else begin
                ptr_reg <= IW'(int'(win) + 1);
            end
        end
    end

endmodule : ssf_arb

/* design/ssf_switch_fabric.sv */
`timescale 1ns/10ps
module ssf_switch_fabric #(
    parameter int NC = ssf_pkg::CFG_NC,
    parameter int EP_LSB = ssf_pkg::CFG_EP_LSB,
    parameter logic [NC-1:0] CPU_ONLY = ssf_pkg::CFG_CPU_ONLY,
    parameter logic [2:0] CPU_PRIORITY = ssf_pkg::CPU_PRI
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ssf_pkg::NM-1:0][2:0] master_priority,
    input wire logic [ssf_pkg::NM-1:0] m_req,
    input wire logic [ssf_pkg::NM-1:0][2:0] m_sel,
    input wire logic [ssf_pkg::NM-1:0] m_we,
    input wire logic [ssf_pkg::NM-1:0][ssf_pkg::AW-1:0] m_addr,
    input wire logic [ssf_pkg::NM-1:0][ssf_pkg::DW-1:0] m_wdata,
    output logic [ssf_pkg::NM-1:0] m_gnt,
    output logic [ssf_pkg::NM-1:0] m_rvalid,
    output logic [ssf_pkg::NM-1:0] m_err,
    output logic [ssf_pkg::NM-1:0][ssf_pkg::DW-1:0] m_rdata,
    output wire logic [ssf_pkg::NS-1:0] dsl_req,
    output wire logic [ssf_pkg::NS-1:0] dsl_we,
    output wire logic [ssf_pkg::NS-1:0][ssf_pkg::AW-1:0] dsl_addr,
    output wire logic [ssf_pkg::NS-1:0][ssf_pkg::DW-1:0] dsl_wdata,
    input wire logic [ssf_pkg::NS-1:0] dsl_ack,
    input wire logic [ssf_pkg::NS-1:0][ssf_pkg::DW-1:0] dsl_rdata,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [ssf_pkg::AW-1:0] cpu_addr,
    input wire logic [ssf_pkg::CW-1:0] cpu_wdata,
    output logic cpu_gnt,
    output logic cpu_rvalid,
    output logic [ssf_pkg::CW-1:0] cpu_rdata,
    output wire logic [NC-1:0] cfg_req,
    output wire logic [NC-1:0] cfg_we,
    output wire logic [NC-1:0][ssf_pkg::AW-1:0] cfg_addr,
    output wire logic [NC-1:0][ssf_pkg::CW-1:0] cfg_wdata,
    input wire logic [NC-1:0] cfg_ack,
    input wire logic [NC-1:0][ssf_pkg::CW-1:0] cfg_rdata
);

    localparam int NM = ssf_pkg::NM;
    localparam int NS = ssf_pkg::NS;
    localparam int OW = ssf_pkg::OW;
    localparam int EW = $clog2(NC);

    logic [NM-1:0] busy_reg;
    logic [NM-1:0] bad_req;
    logic [NM-1:0] bad_pend_reg;
    logic [NS-1:0][NM-1:0] cand;
    logic [NS-1:0][NM-1:0] gnt_s;
    logic [NM-1:0] resp_hit;
    logic [NM-1:0] resp_err;
    logic [NM-1:0][ssf_pkg::DW-1:0] resp_data;

    logic [NS-1:0] ch_xfer;
    logic [NS-1:0] ch_done;
    logic [NS-1:0] ch_err;
    logic [NS-1:0] ch_we;
    logic [NS-1:0][OW-1:0] ch_own;
    logic [NS-1:0][ssf_pkg::AW-1:0] ch_addr;
    logic [NS-1:0][ssf_pkg::CW-1:0] ch_wlo;
    logic [NS-1:0][ssf_pkg::DW-1:0] ch_racc;

    logic br_req;
    logic [EW-1:0] br_ep;
    logic [2:0] br_pri;
    logic br_err_reg;
    logic br_ack;
    logic [ssf_pkg::CW-1:0] br_rdata;
    logic [EW-1:0] cpu_ep;
    logic cpu_busy_reg;
    logic [NC-1:0] ep_gnt_cpu;
    logic [NC-1:0] ep_done;
    logic [NC-1:0] ep_own;
    logic [NC-1:0][ssf_pkg::CW-1:0] ep_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // only masters request
    always_comb begin
        cand = '0;
        bad_req = '0;
        for (int i = 0; i < NM; i++) begin
            if (m_req[i] && !busy_reg[i]) begin
                if (m_sel[i] < 3'(NS) && ssf_pkg::REACH[i][m_sel[i]]) begin
                    cand[m_sel[i]][i] = 1'b1;
                end else begin
                    bad_req[i] = 1'b1;
                end
            end
        end
    end

    always_comb begin
        m_gnt = bad_req;
        for (int s = 0; s < NS; s++) begin
            m_gnt = m_gnt | gnt_s[s];
        end
    end

    always_comb begin
        resp_hit = bad_pend_reg;
        resp_err = bad_pend_reg;
        resp_data = '0;
        for (int i = 0; i < NM; i++) begin
            for (int s = 0; s < NS; s++) begin
                if (ch_done[s] && ch_own[s] == OW'(i)) begin
                    resp_hit[i] = 1'b1;
                    resp_err[i] = ch_err[s];
                    resp_data[i] = ch_racc[s];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one port and one outstanding transfer per master
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_reg <= '0;
            bad_pend_reg <= '0;
            m_rvalid <= '0;
            m_err <= '0;
            m_rdata <= '0;
        end else begin
            bad_pend_reg <= bad_req;
            m_rvalid <= resp_hit;
            m_err <= resp_err;
            for (int i = 0; i < NM; i++) begin
                if (resp_hit[i]) begin
                    busy_reg[i] <= 1'b0;
                    m_rdata[i] <= resp_data[i];
                end else if (m_gnt[i]) begin
                    busy_reg[i] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one independent channel per slave
    for (genvar s = 0; s < NS; s++) begin : g_ch
        localparam int LANE = ssf_pkg::SL_LANE[s];
        localparam int BEATS = ssf_pkg::SL_BEATS[s];
        logic [NM-1:0] arb_req;
        logic [OW-1:0] arb_win;
        logic ack;
        logic ack_err;
        logic [LANE-1:0] rlane;
        ssf_pkg::ssf_state_t st_reg;
        logic [1:0] beat_reg;
        logic [OW-1:0] own_reg;
        logic we_reg;
        logic err_reg;
        logic [ssf_pkg::AW-1:0] addr_reg;
        logic [ssf_pkg::DW-1:0] wfull_reg;
        logic [LANE-1:0] wbeat_reg;
        logic [ssf_pkg::DW-1:0] racc_reg;

        assign arb_req = (st_reg == ssf_pkg::SSF_IDLE) ? cand[s] : '0;

        ssf_arb #(.N(NM)) u_arb (
            .clk_sys(clk_sys),
            .rst(rst),
            .req(arb_req),
            .pri(master_priority),
            .gnt(gnt_s[s]),
            .win(arb_win)
        );

        if (s == int'(ssf_pkg::S_CFG)) begin : g_br
            assign ack = br_ack;
            assign ack_err = br_err_reg;
            assign rlane = br_rdata;
            assign dsl_req[s] = 1'b0;
            assign dsl_we[s] = 1'b0;
            assign dsl_addr[s] = '0;
            assign dsl_wdata[s] = '0;
        end else begin : g_ext
            assign ack = dsl_ack[s];
            assign ack_err = 1'b0;
            assign rlane = dsl_rdata[s][LANE-1:0];
            assign dsl_req[s] = (st_reg == ssf_pkg::SSF_XFER);
            assign dsl_we[s] = we_reg;
            assign dsl_addr[s] = addr_reg;
            assign dsl_wdata[s] = ssf_pkg::DW'(wbeat_reg);
        end

        assign ch_xfer[s] = (st_reg == ssf_pkg::SSF_XFER);
        assign ch_done[s] = (st_reg == ssf_pkg::SSF_RESP);
        assign ch_err[s] = err_reg;
        assign ch_we[s] = we_reg;
        assign ch_own[s] = own_reg;
        assign ch_addr[s] = addr_reg;
        assign ch_wlo[s] = wbeat_reg[ssf_pkg::CW-1:0];
        assign ch_racc[s] = racc_reg;

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                st_reg <= ssf_pkg::SSF_IDLE;
                beat_reg <= 2'h0;
                own_reg <= '0;
                we_reg <= 1'b0;
                err_reg <= 1'b0;
                addr_reg <= '0;
                wfull_reg <= '0;
                wbeat_reg <= '0;
                racc_reg <= '0;
            end else begin
                unique case (st_reg)
                    ssf_pkg::SSF_IDLE: begin
                        if (|arb_req) begin
                            st_reg <= ssf_pkg::SSF_XFER;
                            own_reg <= arb_win;
                            we_reg <= m_we[arb_win];
                            addr_reg <= m_addr[arb_win];
                            wfull_reg <= m_wdata[arb_win];
                            wbeat_reg <= m_wdata[arb_win][LANE-1:0];
                            beat_reg <= 2'h0;
                            err_reg <= 1'b0;
                            racc_reg <= '0;
                        end
                    end
                    ssf_pkg::SSF_XFER: begin
                        if (ack) begin
                            // narrow lanes are filled low beat first
                            racc_reg[int'(beat_reg)*LANE +: LANE] <= rlane;
                            if (int'(beat_reg) == BEATS - 1) begin
                                st_reg <= ssf_pkg::SSF_RESP;
                                err_reg <= ack_err;
                            end else begin
                                beat_reg <= beat_reg + 2'h1;
                                addr_reg <= ssf_pkg::AW'(addr_reg + 32'(LANE / 8));
                                wbeat_reg <= wfull_reg[(int'(beat_reg) + 1)*LANE +: LANE];
                            end
                        end
                    end
                    ssf_pkg::SSF_RESP: begin
                        st_reg <= ssf_pkg::SSF_IDLE;
                    end
                    default: begin
                        st_reg <= ssf_pkg::SSF_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration fabric: processor port and bridge from the data fabric
    assign br_req = ch_xfer[ssf_pkg::S_CFG];
    assign br_ep = ch_addr[ssf_pkg::S_CFG][EP_LSB +: EW];
    assign br_pri = master_priority[ch_own[ssf_pkg::S_CFG]];
    assign cpu_ep = cpu_addr[EP_LSB +: EW];
    assign cpu_gnt = |ep_gnt_cpu;

    always_comb begin
        br_ack = br_err_reg;
        br_rdata = '0;
        for (int e = 0; e < NC; e++) begin
            if (ep_done[e] && ep_own[e]) begin
                br_ack = 1'b1;
                br_rdata = ep_rdata[e];
            end
        end
    end

    // bridge access to a protected endpoint ends in error, one pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            br_err_reg <= 1'b0;
        end else begin
            br_err_reg <= br_req && CPU_ONLY[br_ep] && !br_err_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_busy_reg <= 1'b0;
            cpu_rvalid <= 1'b0;
            cpu_rdata <= '0;
        end else begin
            cpu_rvalid <= |(ep_done & ~ep_own);
            for (int e = 0; e < NC; e++) begin
                if (ep_done[e] && !ep_own[e]) begin
                    cpu_rdata <= ep_rdata[e];
                end
            end
            if (|(ep_done & ~ep_own)) begin
                cpu_busy_reg <= 1'b0;
            end else if (cpu_gnt) begin
                cpu_busy_reg <= 1'b1;
            end
        end
    end

    for (genvar e = 0; e < NC; e++) begin : g_ep
        logic [1:0] req2;
        logic [1:0] gnt2;
        logic win2;
        ssf_pkg::ssf_state_t st_reg;
        logic own_reg;
        logic we_reg;
        logic [ssf_pkg::AW-1:0] addr_reg;
        logic [ssf_pkg::CW-1:0] wdata_reg;
        logic [ssf_pkg::CW-1:0] rdata_reg;

        assign req2[0] = (st_reg == ssf_pkg::SSF_IDLE) && cpu_req && !cpu_busy_reg
                         && cpu_ep == EW'(e);
        assign req2[1] = (st_reg == ssf_pkg::SSF_IDLE) && br_req && br_ep == EW'(e)
                         && !CPU_ONLY[e];

        ssf_arb #(.N(2)) u_arb (
            .clk_sys(clk_sys),
            .rst(rst),
            .req(req2),
            .pri({br_pri, CPU_PRIORITY}),
            .gnt(gnt2),
            .win(win2)
        );

        assign ep_gnt_cpu[e] = gnt2[0];
        assign ep_done[e] = (st_reg == ssf_pkg::SSF_RESP);
        assign ep_own[e] = own_reg;
        assign ep_rdata[e] = rdata_reg;
        assign cfg_req[e] = (st_reg == ssf_pkg::SSF_XFER);
        assign cfg_we[e] = we_reg;
        assign cfg_addr[e] = addr_reg;
        assign cfg_wdata[e] = wdata_reg;

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                st_reg <= ssf_pkg::SSF_IDLE;
                own_reg <= 1'b0;
                we_reg <= 1'b0;
                addr_reg <= '0;
                wdata_reg <= '0;
                rdata_reg <= '0;
            end else begin
                unique case (st_reg)
                    ssf_pkg::SSF_IDLE: begin
                        if (|req2) begin
                            st_reg <= ssf_pkg::SSF_XFER;
                            own_reg <= win2;
                            we_reg <= win2 ? ch_we[ssf_pkg::S_CFG] : cpu_we;
                            addr_reg <= win2 ? ch_addr[ssf_pkg::S_CFG] : cpu_addr;
                            wdata_reg <= win2 ? ch_wlo[ssf_pkg::S_CFG] : cpu_wdata;
                        end
                    end
                    ssf_pkg::SSF_XFER: begin
                        if (cfg_ack[e]) begin
                            st_reg <= ssf_pkg::SSF_RESP;
                            rdata_reg <= cfg_rdata[e];
                        end
                    end
                    ssf_pkg::SSF_RESP: begin
                        st_reg <= ssf_pkg::SSF_IDLE;
                    end
                    default: begin
                        st_reg <= ssf_pkg::SSF_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : ssf_switch_fabric

/* sim/ssf_slave_model.sv */
`timescale 1ns/10ps
module ssf_slave_model #(
    parameter int N = 6,
    parameter int W = 128
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [N-1:0] req,
    input wire logic [N-1:0][31:0] addr,
    input wire logic [N-1:0][W-1:0] wdata,
    input wire logic [3:0] dly,
    output logic [N-1:0] ack,
    output logic [N-1:0][W-1:0] rdata,
    output logic [N-1:0][W-1:0] last_wd,
    output logic [N-1:0][W-1:0] prev_wd
);
    logic [N-1:0][3:0] wait_reg;

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < N; i++) begin
            if (rst) begin
                ack[i] <= 1'b0;
                wait_reg[i] <= 4'h0;
                rdata[i] <= '0;
            end else if (req[i] && !ack[i] && wait_reg[i] >= dly) begin
                ack[i] <= 1'b1;
                wait_reg[i] <= 4'h0;
                rdata[i] <= W'({4{addr[i] ^ 32'hC3C3_0000}});
                prev_wd[i] <= last_wd[i];
                last_wd[i] <= wdata[i];
            end else begin
                ack[i] <= 1'b0;
                wait_reg[i] <= (req[i] && !ack[i]) ? wait_reg[i] + 4'h1 : 4'h0;
                // toggling so that read data sampled one cycle after the ack does not match
                rdata[i] <= ~rdata[i];
            end
        end
    end
endmodule : ssf_slave_model

/* sim/ssf_switch_fabric_asserts.sv */
`timescale 1ns/10ps
module ssf_switch_fabric_asserts #(
    parameter int NC = ssf_pkg::CFG_NC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ssf_pkg::NM-1:0][2:0] master_priority,
    input wire logic [ssf_pkg::NM-1:0] m_req,
    input wire logic [ssf_pkg::NM-1:0][2:0] m_sel,
    input wire logic [ssf_pkg::NM-1:0][ssf_pkg::AW-1:0] m_addr,
    input wire logic [ssf_pkg::NM-1:0] m_gnt,
    input wire logic [ssf_pkg::NM-1:0] m_rvalid,
    input wire logic [ssf_pkg::NM-1:0] m_err,
    input wire logic [ssf_pkg::NS-1:0] dsl_req,
    input wire logic [ssf_pkg::NS-1:0] dsl_ack,
    input wire logic [ssf_pkg::NS-1:0][ssf_pkg::AW-1:0] dsl_addr,
    input wire logic [ssf_pkg::NS-1:0][ssf_pkg::DW-1:0] dsl_wdata,
    input wire logic cpu_gnt,
    input wire logic [ssf_pkg::AW-1:0] cpu_addr,
    input wire logic [NC-1:0] cfg_req
);
    logic [2:0] cpu_ep_reg;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clk_sys) begin
        cpu_ep_reg <= cpu_addr[18:16];
    end

    for (genvar i = 0; i < ssf_pkg::NM; i++) begin : g_m
        wire logic ok = m_sel[i] < 3'h6 && ssf_pkg::REACH[i][m_sel[i]];
        wire logic lock = m_sel[i] == ssf_pkg::S_CFG && m_addr[i][18:16] < 3'h3;
        illegal_err_a: assert property (m_gnt[i] && !ok |-> ##2 m_rvalid[i] && m_err[i])
            else $error("unreachable target not refused");
        early_resp_a: assert property (m_gnt[i] && ok && !lock |=> !m_rvalid[i] [*2])
            else $error("response too early");
        cpu_only_a: assert property (
            m_gnt[i] && ok && lock |-> ##[1:4] (m_rvalid[i] && m_err[i]))
            else $error("locked endpoint reached by bridge master");
        for (genvar j = 0; j < ssf_pkg::NM; j++) begin : g_o
            if (j != i) begin : g_p
                prio_win_a: assert property (
                    m_gnt[i] && m_req[j] && m_sel[j] == m_sel[i] && ok
                    && m_sel[i] != ssf_pkg::S_CFG && ssf_pkg::REACH[j][m_sel[i]]
                    |-> master_priority[i] <= master_priority[j])
                    else $error("lower priority master granted first");
            end
        end
    end

    err_pulse_a: assert property ((m_err & ~m_rvalid) == '0)
        else $error("error flag without response");
    beat_addr_a: assert property (dsl_ack[3] && !dsl_addr[3][3]
        |=> dsl_req[3] && dsl_addr[3] == $past(dsl_addr[3]) + 32'h8)
        else $error("second memory beat missing or misplaced");
    lane_zero_a: assert property (dsl_req[0] |-> dsl_wdata[0][127:32] == '0)
        else $error("serial lane upper bits not zero");
    cpu_route_a: assert property (cpu_gnt |=> cfg_req[cpu_ep_reg])
        else $error("processor request not routed");
    resp_lat_a: assert property (dsl_ack[2] || dsl_ack[5] |-> ##2 m_rvalid != '0)
        else $error("direct slave response late");
endmodule : ssf_switch_fabric_asserts

bind ssf_switch_fabric ssf_switch_fabric_asserts #(.NC(NC)) u_asserts (.*);

/* sim/tb_system_switch_fabric.sv */
`timescale 1ns/10ps
`define CHK(g, e) \
    begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_system_switch_fabric;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [6:0][2:0] master_priority = '0;
    logic [6:0] m_req = '0;
    logic [6:0] m_we = '0;
    logic [6:0][2:0] m_sel = '0;
    logic [6:0][31:0] m_addr = '0;
    logic [6:0][127:0] m_wdata = '0;
    logic [6:0] m_gnt, m_rvalid, m_err;
    logic [6:0][127:0] m_rdata;
    logic [5:0] dsl_req, dsl_we, dsl_ack;
    logic [5:0][31:0] dsl_addr;
    logic [5:0][127:0] dsl_wdata, dsl_rdata, last_wd, prev_wd;
    logic cpu_req = 1'b0;
    logic cpu_we = 1'b0;
    logic [31:0] cpu_addr = '0;
    logic [31:0] cpu_wdata = '0;
    logic cpu_gnt, cpu_rvalid;
    logic [31:0] cpu_rdata;
    logic [7:0] cfg_req, cfg_we, cfg_ack;
    logic [7:0][31:0] cfg_addr, cfg_wdata, cfg_rdata;
    logic [3:0] dly = 4'h0;
    logic [5:0] reach [7] = '{6'h38, 6'h3F, 6'h3C, 6'h3C, 6'h38, 6'h3A, 6'h3A};
    int n_fail = 0;
    int n_checks = 0;

    ssf_switch_fabric dut (.*);
    ssf_slave_model #(.N(6), .W(128)) u_dsl (.clk_sys(clk_sys), .rst(rst), .req(dsl_req),
        .addr(dsl_addr), .wdata(dsl_wdata), .dly(dly), .ack(dsl_ack), .rdata(dsl_rdata),
        .last_wd(last_wd), .prev_wd(prev_wd));
    ssf_slave_model #(.N(8), .W(32)) u_cfg (.clk_sys(clk_sys), .rst(rst), .req(cfg_req),
        .addr(cfg_addr), .wdata(cfg_wdata), .dly(dly), .ack(cfg_ack), .rdata(cfg_rdata),
        .last_wd(), .prev_wd());

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////
    function automatic logic [127:0] exp_rd(input logic [2:0] s, input logic [31:0] a);
        logic [127:0] p;
        logic [127:0] q;
        p = {4{a ^ 32'hC3C3_0000}};
        q = {4{(a + 32'h8) ^ 32'hC3C3_0000}};
        if (s < 3'h2) return {96'h0, p[31:0]};
        if (s == 3'h3 || s == 3'h4) return {q[63:0], p[63:0]};
        return p;
    endfunction : exp_rd

    task automatic xfer(input int m, input logic [2:0] s, input logic we, input logic [31:0] a,
            input logic [127:0] wd, input logic e, input logic [127:0] rd, output time t);
        int k;
        @(negedge clk_sys);
        m_req[m] = 1'b1;
        m_sel[m] = s;
        m_we[m] = we;
        m_addr[m] = a;
        m_wdata[m] = wd;
        k = 0;
        #1;
        while (m_gnt[m] !== 1'b1 && k < 300) begin
            @(negedge clk_sys);
            #1;
            k++;
        end
        t = $time;
        @(negedge clk_sys);
        m_req[m] = 1'b0;
        while (m_rvalid[m] !== 1'b1 && k < 600) begin
            @(negedge clk_sys);
            k++;
        end
        `CHK(m_rvalid[m], 1'b1)
        `CHK(m_err[m], e)
        if (!e && !we) `CHK(m_rdata[m], rd)
    endtask : xfer

    task automatic cpu_x(input logic [31:0] a, output time t);
        int k;
        @(negedge clk_sys);
        cpu_req = 1'b1;
        cpu_addr = a;
        k = 0;
        #1;
        while (cpu_gnt !== 1'b1 && k < 300) begin
            @(negedge clk_sys);
            #1;
            k++;
        end
        t = $time;
        @(negedge clk_sys);
        cpu_req = 1'b0;
        while (cpu_rvalid !== 1'b1 && k < 600) begin
            @(negedge clk_sys);
            k++;
        end
        `CHK(cpu_rvalid, 1'b1)
        `CHK(cpu_rdata, a ^ 32'hC3C3_0000)
    endtask : cpu_x

    task automatic race(input int ma, input int mb, input logic [2:0] s, output time ta,
            output time tb);
        fork
            xfer(ma, s, 1'b0, 32'h0004_0000, '0, 1'b0, exp_rd(s, 32'h0004_0000), ta);
            xfer(mb, s, 1'b0, 32'h0004_0000, '0, 1'b0, exp_rd(s, 32'h0004_0000), tb);
        join
    endtask : race

    ////////////////////////////////////////
    task automatic t_matrix;
        logic [31:0] a;
        time t;
        for (int m = 0; m < 7; m++) begin
            for (int s = 0; s < 7; s++) begin
                a = 32'h0004_0000 + 32'(m * 256);
                xfer(m, 3'(s), 1'b0, a, '0, s > 5 || !reach[m][s], exp_rd(3'(s), a), t);
            end
        end
    endtask : t_matrix

    task automatic t_write;
        time t;
        logic [127:0] w;
        w = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
        dly = 4'h3;
        xfer(1, 3'h3, 1'b1, 32'h0004_0000, w, 1'b0, '0, t);
        `CHK(prev_wd[3], {64'h0, w[63:0]})
        `CHK(last_wd[3], {64'h0, w[127:64]})
        `CHK(dsl_we[3], 1'b1)
        xfer(1, 3'h0, 1'b1, 32'h0004_0000, w, 1'b0, '0, t);
        `CHK(last_wd[0], {96'h0, w[31:0]})
        xfer(1, ssf_pkg::S_CFG, 1'b1, 32'h0004_0000, w, 1'b0, '0, t);
        `CHK(cfg_we[4], 1'b1)
        `CHK(cfg_wdata[4], w[31:0])
        xfer(1, 3'h4, 1'b0, 32'h0004_0000, '0, 1'b0, exp_rd(3'h4, 32'h0004_0000), t);
        dly = 4'h0;
    endtask : t_write

    task automatic t_cpu;
        time t;
        for (int e = 0; e < 3; e++) begin
            xfer(5, ssf_pkg::S_CFG, 1'b0, 32'(e) << 16, '0, 1'b1, '0, t);
            cpu_x(32'(e) << 16, t);
        end
    endtask : t_cpu

    task automatic t_prio;
        time ta;
        time tb;
        master_priority[2] = 3'h5;
        master_priority[3] = 3'h2;
        race(2, 3, 3'h2, ta, tb);
        `CHK(tb < ta, 1'b1)
        master_priority[2] = 3'h0;
        master_priority[3] = 3'h7;
        race(2, 3, 3'h2, ta, tb);
        `CHK(ta < tb, 1'b1)
        master_priority[3] = 3'h0;
        race(2, 3, 3'h2, ta, tb);
        `CHK(ta < tb, 1'b1)
        xfer(2, 3'h2, 1'b0, 32'h0004_0000, '0, 1'b0, exp_rd(3'h2, 32'h0004_0000), ta);
        race(2, 3, 3'h2, ta, tb);
        `CHK(tb < ta, 1'b1)
        master_priority[5] = 3'h6;
        master_priority[6] = 3'h1;
        race(5, 6, ssf_pkg::S_CFG, ta, tb);
        `CHK(tb < ta, 1'b1)
        fork
            xfer(0, 3'h3, 1'b0, 32'h0004_0000, '0, 1'b0, exp_rd(3'h3, 32'h0004_0000), ta);
            xfer(1, 3'h5, 1'b0, 32'h0004_0000, '0, 1'b0, exp_rd(3'h5, 32'h0004_0000), tb);
        join
        `CHK(ta, tb)
        // processor and bridge master share an endpoint
        fork
            cpu_x(32'h0004_0000, ta);
            xfer(6, ssf_pkg::S_CFG, 1'b0, 32'h0004_0000, '0, 1'b0,
                exp_rd(3'h1, 32'h0004_0000), tb);
        join
    endtask : t_prio

    task automatic close_out;
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        t_matrix;
        t_write;
        t_cpu;
        t_prio;
        close_out;
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out;
    end
endmodule : tb_system_switch_fabric
